// [design/spi_status_pkg.sv]
// Package: register map, field positions and reset values of the block
package spi_status_pkg;
  localparam logic [3:0]  OFS_STATUS  = 4'h0;
  localparam logic [3:0]  OFS_DIVISOR = 4'h4;
  localparam logic [3:0]  OFS_CONTROL = 4'h8;
  localparam logic [3:0]  OFS_DATA    = 4'hC;
  localparam logic [7:0]  OFS_IRQ_ST  = 8'h10;
  localparam logic [7:0]  OFS_IRQ_EN  = 8'h14;
  localparam logic [7:0]  OFS_IRQ_CLR = 8'h18;
  localparam logic [7:0]  OFS_LINK    = 8'h1C;
  localparam int          BIT_RBF     = 0;
  localparam int          BIT_TBF     = 1;
  localparam int          BIT_UNIMP   = 2;
  localparam int          BIT_TBE     = 3;
  localparam int          BIT_RBE     = 5;
  localparam int          DIV_W       = 13;
  localparam int          WORD_W      = 8;
  localparam int          PTR_W       = 4;
  localparam int          IRQ_N       = 3;
  localparam logic [12:0] DIV_RESET   = 13'h0000;
endpackage

// [design/spi_tx_path.sv]
// Transmit holding buffer or FIFO with its status flags
`timescale 1ns/1ps
`default_nettype none
module spi_tx_path (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_enh,
  input  wire logic       i_wr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_take,
  output logic [7:0]      o_word,
  output logic            o_avail,
  output logic            o_full,
  output logic            o_empty
);
  localparam int PW = spi_status_pkg::PTR_W;
  logic [7:0]    mem [0:15];
  logic [PW-1:0] cpu_write_pointer;
  logic [PW-1:0] serial_read_pointer;
  logic          std_full;
  logic          empty_flag;
  wire  [PW-1:0] wp_inc = cpu_write_pointer + 1'b1;
  wire  fifo_full  = (wp_inc == serial_read_pointer);
  wire  fifo_avail = (cpu_write_pointer != serial_read_pointer);
  wire  do_wr = i_wr & ~o_full;
  wire  do_take = i_take & o_avail;
  assign o_avail = i_enh ? fifo_avail : std_full;
  assign o_full  = i_enh ? fifo_full : std_full;
  assign o_word  = mem[serial_read_pointer];
  assign o_empty = empty_flag;
  always_ff @(posedge i_clk) begin
    if (do_wr) begin
      mem[cpu_write_pointer] <= i_wdata;
    end
  end
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cpu_write_pointer   <= '0;
      serial_read_pointer <= '0;
      std_full            <= 1'b0;
      empty_flag          <= 1'b1;
    end else if (!i_enh) begin
      cpu_write_pointer   <= '0;
      serial_read_pointer <= '0;
      if (do_wr) begin
        std_full   <= 1'b1;
        empty_flag <= 1'b0;
      end else if (do_take) begin
        std_full   <= 1'b0;
        empty_flag <= 1'b1;
      end
    end else begin
      std_full <= 1'b0;
      if (do_wr) begin
        cpu_write_pointer <= wp_inc;
      end
      if (do_take) begin
        serial_read_pointer <= serial_read_pointer + 1'b1;
      end
      if (do_wr) begin
        empty_flag <= 1'b0;
      end else if (do_take) begin
        empty_flag <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// [design/spi_rx_path.sv]
// Receive holding buffer or FIFO with its status flags
`timescale 1ns/1ps
`default_nettype none
module spi_rx_path (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_enh,
  input  wire logic       i_put,
  input  wire logic [7:0] i_word,
  input  wire logic       i_rd,
  output logic [7:0]      o_rdata,
  output logic            o_full,
  output logic            o_empty
);
  localparam int PW = spi_status_pkg::PTR_W;
  logic [7:0]    mem [0:15];
  logic [PW-1:0] serial_write_pointer;
  logic [PW-1:0] cpu_read_pointer;
  logic          std_full;
  wire  [PW-1:0] wp_inc = serial_write_pointer + 1'b1;
  wire  fifo_full  = (wp_inc == cpu_read_pointer);
  wire  fifo_empty = (cpu_read_pointer == serial_write_pointer);
  wire  do_put = i_put & ~o_full;
  wire  do_rd  = i_rd & ~o_empty;
  assign o_full  = i_enh ? fifo_full : std_full;
  assign o_empty = i_enh ? fifo_empty : ~std_full;
  assign o_rdata = mem[cpu_read_pointer];
  always_ff @(posedge i_clk) begin
    if (do_put) begin
      mem[serial_write_pointer] <= i_word;
    end
  end
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      serial_write_pointer <= '0;
      cpu_read_pointer     <= '0;
      std_full             <= 1'b0;
    end else if (!i_enh) begin
      serial_write_pointer <= '0;
      cpu_read_pointer     <= '0;
      if (do_put) begin
        std_full <= 1'b1;
      end else if (do_rd) begin
        std_full <= 1'b0;
      end
    end else begin
      std_full <= 1'b0;
      if (do_put) begin
        serial_write_pointer <= wp_inc;
      end
      if (do_rd) begin
        cpu_read_pointer <= cpu_read_pointer + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// [design/spi_status_top.sv]
// Serial port buffer status, clock divisor and Wishbone register slave
// Function
// - Transmit-empty sets when a held word moves to the shift register.
// - Transmit-empty clears when software writes the data port.
// - Standard mode: transmit-full sets on a data port write.
// - Standard mode: transmit-full clears when the shifter takes the word.
// - Enhanced: transmit-full iff write ptr + 1 equals read ptr.
// - Standard mode: receive-full sets when a shifted word is held.
// - Standard mode: receive-full clears on a data port read.
// - Enhanced: receive-full iff serial write ptr + 1 equals read ptr.
// - Divisor holds a 13-bit read/write field, zero after reset.
// - Divisor bits 31 to 13 store nothing; software writes zero.
// - Status bit 2 always reads zero.
// - FIFO behaviour only while enhanced-buffer enable is one.
// - Enhanced: receive-empty when read pointer equals write pointer.
//
// Register access over Wishbone and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module spi_status_top (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [7:0]  i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output logic [31:0]      o_wb_dat,
  output logic             o_wb_ack,
  input  wire logic        i_shift_load,
  input  wire logic        i_shift_done,
  input  wire logic [7:0]  i_shift_rx,
  output logic [7:0]       o_shift_tx,
  output logic             o_shift_tx_valid,
  output logic [12:0]      o_baud_divisor,
  output logic             o_irq
);
  logic [12:0] baud_divisor_field;
  logic        enhanced_buffer_enable;
  logic [2:0]  irq_status;
  logic [2:0]  irq_enable;
  logic [7:0]  tx_word;
  logic [7:0]  rx_word;
  logic        tx_avail;
  logic        tx_buffer_full_flag;
  logic        tx_buffer_empty_flag;
  logic        rx_buffer_full_flag;
  logic        rx_fifo_empty_flag;
  logic        tbe_q;
  logic        rbf_q;
  logic [31:0] next_rdata;

  wire req     = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  wire wr_req  = req & i_wb_we;
  wire rd_req  = req & ~i_wb_we;
  wire [7:0] adr = {i_wb_adr[7:2], 2'b00};
  wire hit_stat = (adr == {4'h0, spi_status_pkg::OFS_STATUS});
  wire hit_div  = (adr == {4'h0, spi_status_pkg::OFS_DIVISOR});
  wire hit_ctl  = (adr == {4'h0, spi_status_pkg::OFS_CONTROL});
  wire hit_data = (adr == {4'h0, spi_status_pkg::OFS_DATA});
  wire hit_ist  = (adr == spi_status_pkg::OFS_IRQ_ST);
  wire hit_ien  = (adr == spi_status_pkg::OFS_IRQ_EN);
  wire hit_iclr = (adr == spi_status_pkg::OFS_IRQ_CLR);
  wire data_wr  = wr_req & hit_data & i_wb_sel[0];
  wire data_rd  = rd_req & hit_data;

  // Shifter takes the held word only when one is there
  wire tx_take = i_shift_load & tx_avail;

  spi_tx_path spi_tx_path_inst (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_enh   (enhanced_buffer_enable),
    .i_wr    (data_wr),
    .i_wdata (i_wb_dat[7:0]),
    .i_take  (tx_take),
    .o_word  (tx_word),
    .o_avail (tx_avail),
    .o_full  (tx_buffer_full_flag),
    .o_empty (tx_buffer_empty_flag)
  );

  spi_rx_path spi_rx_path_inst (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_enh   (enhanced_buffer_enable),
    .i_put   (i_shift_done),
    .i_word  (i_shift_rx),
    .i_rd    (data_rd),
    .o_rdata (rx_word),
    .o_full  (rx_buffer_full_flag),
    .o_empty (rx_fifo_empty_flag)
  );

  // Status image: flags come only from hardware, writes do not reach them
  wire [31:0] status_word = {26'h000_0000,
                             rx_fifo_empty_flag & enhanced_buffer_enable,
                             1'b0,
                             tx_buffer_empty_flag,
                             1'b0,
                             tx_buffer_full_flag,
                             rx_buffer_full_flag};

  // Interrupt events: transmit-empty rise, receive-full rise, rx word put
  wire tbe_rise = tx_buffer_empty_flag & ~tbe_q;
  wire rbf_rise = rx_buffer_full_flag & ~rbf_q;
  wire [2:0] irq_event = {i_shift_done, rbf_rise, tbe_rise};
  wire [2:0] irq_clr = (wr_req & hit_iclr) ? i_wb_dat[2:0] : 3'b000;
  // Set wins over a clear in the same cycle
  wire [2:0] next_irq_status = irq_event | (irq_status & ~irq_clr);

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (hit_stat) begin
      next_rdata = status_word;
    end else if (hit_div) begin
      next_rdata = {19'h0_0000, baud_divisor_field};
    end else if (hit_ctl) begin
      next_rdata = {31'h0000_0000, enhanced_buffer_enable};
    end else if (hit_data) begin
      next_rdata = {24'h00_0000, rx_word};
    end else if (hit_ist) begin
      next_rdata = {29'h0000_0000, irq_status};
    end else if (hit_ien) begin
      next_rdata = {29'h0000_0000, irq_enable};
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
    end else begin
      o_wb_ack <= req;
      o_wb_dat <= rd_req ? next_rdata : 32'h0000_0000;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      baud_divisor_field <= spi_status_pkg::DIV_RESET;
    end else if (wr_req && hit_div) begin
      if (i_wb_sel[0]) begin
        baud_divisor_field[7:0] <= i_wb_dat[7:0];
      end
      if (i_wb_sel[1]) begin
        baud_divisor_field[12:8] <= i_wb_dat[12:8];
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      enhanced_buffer_enable <= 1'b0;
      irq_enable             <= 3'b000;
    end else begin
      if (wr_req && hit_ctl && i_wb_sel[0]) begin
        enhanced_buffer_enable <= i_wb_dat[0];
      end
      if (wr_req && hit_ien && i_wb_sel[0]) begin
        irq_enable <= i_wb_dat[2:0];
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      irq_status       <= 3'b000;
      tbe_q            <= 1'b1;
      rbf_q            <= 1'b0;
      o_irq            <= 1'b0;
      o_shift_tx       <= 8'h00;
      o_shift_tx_valid <= 1'b0;
      o_baud_divisor   <= 13'h0000;
    end else begin
      irq_status       <= next_irq_status;
      tbe_q            <= tx_buffer_empty_flag;
      rbf_q            <= rx_buffer_full_flag;
      o_irq            <= |(next_irq_status & irq_enable);
      o_shift_tx       <= tx_take ? tx_word : o_shift_tx;
      o_shift_tx_valid <= tx_take;
      o_baud_divisor   <= baud_divisor_field;
    end
  end
endmodule
`default_nettype wire

// [tb/spi_status_top_asserts.sv]
// Port-level assertions for the serial port status block
`timescale 1ns/1ps
`default_nettype none
module spi_status_top_asserts (
  input wire logic        i_clk,
  input wire logic        i_rst,
  input wire logic        i_wb_cyc,
  input wire logic        i_wb_stb,
  input wire logic        i_wb_we,
  input wire logic [7:0]  i_wb_adr,
  input wire logic [3:0]  i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  input wire logic [31:0] o_wb_dat,
  input wire logic        o_wb_ack,
  input wire logic        i_shift_load,
  input wire logic        i_shift_done,
  input wire logic [7:0]  i_shift_rx,
  input wire logic [7:0]  o_shift_tx,
  input wire logic        o_shift_tx_valid,
  input wire logic [12:0] o_baud_divisor,
  input wire logic        o_irq
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  wire take  = i_wb_cyc & i_wb_stb & !o_wb_ack;
  wire rd_st = take & !i_wb_we & (i_wb_adr[7:2] == 6'h00);
  wire rd_dv = take & !i_wb_we & (i_wb_adr[7:2] == 6'h01);
  wire wr_dv = take & i_wb_we & (i_wb_adr[7:2] == 6'h01) & (i_wb_sel == 4'hF);
  property p_ack; take |=> o_wb_ack; endproperty
  a_ack: assert property (p_ack) else $error("ack missing");
  property p_pulse; o_wb_ack |=> !o_wb_ack; endproperty
  a_pulse: assert property (p_pulse) else $error("ack held");
  property p_idle; !o_wb_ack |-> o_wb_dat == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("data without ack");
  property p_unimp; rd_st |=> o_wb_dat[2] == 1'b0; endproperty
  a_unimp: assert property (p_unimp) else $error("status bit 2 set");
  property p_div_hi; rd_dv |=> o_wb_dat[31:13] == 19'h0; endproperty
  a_div_hi: assert property (p_div_hi) else $error("divisor top");
  property p_div_rd; rd_dv |=> o_wb_dat[12:0] == o_baud_divisor; endproperty
  a_div_rd: assert property (p_div_rd) else $error("divisor read");
  property p_div_wr;
    wr_dv |-> ##2 o_baud_divisor == $past(i_wb_dat[12:0], 2);
  endproperty
  a_div_wr: assert property (p_div_wr) else $error("divisor write");
  property p_tx_src; o_shift_tx_valid |-> $past(i_shift_load); endproperty
  a_tx_src: assert property (p_tx_src) else $error("tx no load");
endmodule
`default_nettype wire

// [tb/spi_shift_model.sv]
// Far-side shift device: loads words on request and echoes them inverted
`timescale 1ns/1ps
`default_nettype none
module spi_shift_model (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_req,
  input  wire logic       i_slow,
  input  wire logic [7:0] i_tx,
  input  wire logic       i_tx_valid,
  output logic            o_load,
  output logic            o_done,
  output logic [7:0]      o_rx
);
  logic       pend;
  logic [7:0] word;
  wire        fire = i_slow ? pend : i_tx_valid;
  wire  [7:0] src  = i_slow ? word : i_tx;
  assign o_load = i_req;
  // Idle line toggles so a stale word is never taken for fresh data
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pend   <= 1'b0;
      word   <= 8'h00;
      o_done <= 1'b0;
      o_rx   <= 8'h00;
    end else begin
      pend   <= i_tx_valid;
      word   <= i_tx;
      o_done <= fire;
      o_rx   <= fire ? ~src : ~o_rx;
    end
  end
endmodule
`default_nettype wire

// [tb/test_spi_buffer_status_and_divisor.sv]
// Self-checking bench for the serial port buffer status block
`timescale 1ns/1ps
`default_nettype none
module test_spi_buffer_status_and_divisor;
  logic        i_clk, i_rst, cyc, stb, we, ack, req, slow, load, done, txv;
  logic        irq;
  logic [3:0]  sel;
  logic [7:0]  adr, rx, tx;
  logic [12:0] baud;
  logic [31:0] wdat, rdat, q;
  int          fails, comparisons;
  spi_status_top spi_status_top_inst (
    .i_clk(i_clk), .i_rst(i_rst), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
    .o_wb_dat(rdat), .o_wb_ack(ack), .i_shift_load(load),
    .i_shift_done(done), .i_shift_rx(rx), .o_shift_tx(tx),
    .o_shift_tx_valid(txv), .o_baud_divisor(baud), .o_irq(irq));
  spi_shift_model spi_shift_model_inst (
    .i_clk(i_clk), .i_rst(i_rst), .i_req(req), .i_slow(slow), .i_tx(tx),
    .i_tx_valid(txv), .o_load(load), .o_done(done), .o_rx(rx));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, output logic [31:0] r);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    sel  <= s;
    wdat <= d;
    // No cycle count is assumed here; a lost ack is left to the watchdog
    do begin
      @(posedge i_clk);
    end while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d, 4'hF, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0, 4'hF, q);
    chk(q, e);
  endtask
  // Word must appear the cycle after the load request is taken
  task automatic shift_one(input logic [7:0] e);
    req <= 1'b1;
    @(posedge i_clk);
    req <= 1'b0;
    @(posedge i_clk);
    chk({23'h0, txv, tx}, {23'h0, 1'b1, e});
  endtask
  task automatic t_reset;
    rd(8'h00, 32'h0000_0008);
    rd(8'h04, 32'h0000_0000);
    rd(8'h1C, 32'h0000_0000);
  endtask
  task automatic t_div;
    wr(8'h04, 32'h0000_1A5C);
    rd(8'h04, 32'h0000_1A5C);
    wb(1'b1, 8'h04, 32'h0000_00FF, 4'h1, q);
    rd(8'h04, 32'h0000_1AFF);
    chk({19'h0, baud}, 32'h0000_1AFF);
  endtask
  task automatic t_std;
    wr(8'h14, 32'h0000_0007);
    rd(8'h14, 32'h0000_0007);
    wr(8'h0C, 32'h0000_005A);
    rd(8'h00, 32'h0000_0002);
    wr(8'h0C, 32'h0000_00C3);
    wr(8'h00, 32'h0000_000F);
    rd(8'h00, 32'h0000_0002);
    shift_one(8'h5A);
    repeat (3) @(posedge i_clk);
    rd(8'h00, 32'h0000_0009);
    rd(8'h10, 32'h0000_0007);
    chk({31'h0, irq}, 32'h0000_0001);
    rd(8'h0C, 32'h0000_00A5);
    rd(8'h00, 32'h0000_0008);
    wr(8'h18, 32'h0000_0007);
    rd(8'h10, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0000_0000);
  endtask
  // Interrupts stay masked here while every event fires again
  task automatic t_enh;
    wr(8'h14, 32'h0000_0000);
    wr(8'h08, 32'h0000_0001);
    rd(8'h00, 32'h0000_0028);
    for (int i = 0; i < 14; i++) wr(8'h0C, 32'(i));
    rd(8'h00, 32'h0000_0020);
    wr(8'h0C, 32'h0000_000E);
    rd(8'h00, 32'h0000_0022);
    slow <= 1'b1;
    for (int i = 0; i < 15; i++) shift_one(8'(i));
    repeat (4) @(posedge i_clk);
    rd(8'h00, 32'h0000_0009);
    chk({31'h0, irq}, 32'h0000_0000);
    rd(8'h0C, 32'h0000_00FF);
    rd(8'h00, 32'h0000_0008);
  endtask
  // Reset in mid-run must bring back the power-on state
  task automatic t_rst;
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    rd(8'h00, 32'h0000_0008);
    rd(8'h08, 32'h0000_0000);
    rd(8'h04, 32'h0000_0000);
    rd(8'h10, 32'h0000_0000);
    chk({19'h0, baud}, 32'h0000_0000);
  endtask
  task automatic finish_test;
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  initial begin
    repeat (5000) @(posedge i_clk);
    fails++;
    $display("[ERR] %0t timeout", $time);
    finish_test;
  end
  initial begin
    {i_rst, cyc, stb, we, req, slow} = 6'b10_0000;
    {adr, sel, wdat} = '0;
    repeat (4) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    t_reset;
    t_div;
    t_std;
    t_enh;
    t_rst;
    finish_test;
  end
endmodule
bind spi_status_top spi_status_top_asserts spi_status_top_asserts_inst (
  .i_clk, .i_rst, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_sel,
  .i_wb_dat, .o_wb_dat, .o_wb_ack, .i_shift_load, .i_shift_done,
  .i_shift_rx, .o_shift_tx, .o_shift_tx_valid, .o_baud_divisor, .o_irq);
`default_nettype wire
